// ==== rtl/clk_mode_pkg.sv ====
/*
  shared constants and types of the clock mode and tick generator.
  assumes a 32-bit AXI4-Lite register slave with a 4-bit byte address.
*/
`default_nettype none
package clk_mode_pkg;
  // ====================
  // configuration word
  localparam int unsigned CFG_RANGE_BIT = 27;
  localparam int unsigned CFG_UPPER_LO = 28;
  localparam int unsigned CFG_UPPER_HI = 31;
  // ====================
  // register map
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_MODE_STATUS = 4'h0;
  localparam logic [3:0] OFS_FACTORS = 4'h4;
  localparam logic [3:0] OFS_TICK_CTRL = 4'h8;
  localparam logic [3:0] OFS_TICK_STATUS = 4'hC;
  localparam int unsigned ST_RANGE = 7;
  localparam int unsigned ST_AGENT = 8;
  localparam int unsigned ST_VALID = 9;
  localparam int unsigned ST_CAPT = 10;
  localparam int unsigned FAC_CORE_LO = 4;
  localparam int unsigned FAC_PCI_LO = 12;
  localparam int unsigned TS_TICK_LO = 16;
  localparam logic [1:0] PGM_TICK_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ====================
  // tick placement, as fractions of the input clock period
  localparam int unsigned PERIOD_W = 16;
  localparam logic [3:0] RATIO_2P5_X2 = 4'h5;
  localparam logic [3:0] RATIO_3P5_X2 = 4'h7;
  localparam logic [4:0] FR_INT_T2 = 5'h01;
  localparam logic [4:0] FR_INT_T4 = 5'h03;
  localparam logic [4:0] FR_INT_DEN = 5'h04;
  localparam logic [4:0] FR_2P5_T2 = 5'h03;
  localparam logic [4:0] FR_2P5_T4 = 5'h08;
  localparam logic [4:0] FR_2P5_DEN = 5'h0A;
  localparam logic [4:0] FR_3P5_T2 = 5'h04;
  localparam logic [4:0] FR_3P5_T4 = 5'h0B;
  localparam logic [4:0] FR_3P5_DEN = 5'h0E;
  // ====================
  // types
  typedef struct packed {
    logic valid;
    logic [3:0] modX2;
    logic [4:0] coreX2;
    logic [3:0] pciDiv;
  } factors_t;
  typedef enum logic [0:0] {CAP_WAIT, CAP_HELD} cap_state_t;
endpackage : clk_mode_pkg
`default_nettype wire

// ==== rtl/tick_if.sv ====
/*
  link between the mode logic and the tick generator.
  assumes both ends run on the same clock.
*/
`default_nettype none
interface tick_if;
  import clk_mode_pkg::*;
  logic busRise;
  logic busFall;
  logic [3:0] ratioX2;
  logic [3:0] tick;
  logic [PERIOD_W-1:0] period;
  modport gen (input busRise, input busFall, input ratioX2, output tick, output period);
  modport sink (output busRise, output busFall, output ratioX2, input tick, input period);
endinterface : tick_if
`default_nettype wire

// ==== rtl/tick_phase_gen.sv ====
/*
  four internal ticks per bus input clock cycle.
  assumes edge pulses come from a synchronised input clock much slower than clock.
*/
`default_nettype none
module tick_phase_gen (
  input wire logic clock,
  input wire logic nrst,
  tick_if.gen tk
);
  import clk_mode_pkg::*;

  logic [PERIOD_W-1:0] count, next_count, period, next_period;
  logic fired2, next_fired2, fired4, next_fired4;
  logic [3:0] tick, next_tick;
  logic [4:0] num2, num4, den;
  logic hit2, hit4;

  function automatic logic frac_hit(input logic [PERIOD_W-1:0] c, input logic [PERIOD_W-1:0] p,
                                    input logic [4:0] n, input logic [4:0] d);
    frac_hit = (p != '0) && (({5'h00, c} * d) >= ({5'h00, p} * n));
  endfunction : frac_hit

  // ====================
  // tick placement
  always_comb begin
    if (tk.ratioX2 == RATIO_2P5_X2) begin
      num2 = FR_2P5_T2;
      num4 = FR_2P5_T4;
      den = FR_2P5_DEN;
    end else if (tk.ratioX2 == RATIO_3P5_X2) begin
      num2 = FR_3P5_T2;
      num4 = FR_3P5_T4;
      den = FR_3P5_DEN;
    end else begin
      num2 = FR_INT_T2;
      num4 = FR_INT_T4;
      den = FR_INT_DEN;
    end
    hit2 = !fired2 && frac_hit(count, period, num2, den);
    hit4 = !fired4 && frac_hit(count, period, num4, den);
    next_count = (count == '1) ? count : count + 1'b1;
    next_period = period;
    next_fired2 = fired2 | hit2;
    next_fired4 = fired4 | hit4;
    if (tk.busRise) begin
      next_count = '0;
      next_period = count + 1'b1;
      next_fired2 = 1'b0;
      next_fired4 = 1'b0;
    end
    next_tick = {hit4 && !tk.busRise, tk.busFall, hit2 && !tk.busRise, tk.busRise};
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      count <= '0;
      period <= '0;
      fired2 <= 1'b0;
      fired4 <= 1'b0;
      tick <= 4'h0;
    end else begin
      count <= next_count;
      period <= next_period;
      fired2 <= next_fired2;
      fired4 <= next_fired4;
      tick <= next_tick;
    end
  end

  assign tk.tick = tick;
  assign tk.period = period;

  // ====================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_first_on_rise: assert property (nrst && tk.busRise |=> tk.tick[0])
    else $error("first tick missing after rising edge");
  a_third_on_fall: assert property (nrst && tk.busFall |=> tk.tick[2] && !tk.tick[0])
    else $error("third tick missing after falling edge");
endmodule : tick_phase_gen
`default_nettype wire

// ==== rtl/clock_mode_and_tick_generator.sv ====
/*
  clock mode capture at power-on reset, mode factor table, register slave
  and memory controller output timing on the four internal ticks.
  assumes straps and configuration word hold steady while nrst is low,
  and the bus input clock pin is far slower than clock.
*/
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
// What this block does
// - host strap and range bit together pick the clocking mode
// - range bit comes from configuration word bit 27
// - seven-bit mode code: word bits 28 to 31 above three pin bits
// - each mode code in the table gives fixed multiply and divide factors; other codes and agent mode give zero
// - configuration changes only through power-on reset
// - in host mode the input clock is the bus clock
// - four internal ticks per input clock cycle
// - first tick at rising edge, third at falling edge
// - integer ratios: second at one quarter, fourth at three quarters
// - ratio 2.5: 3/10 and 8/10; ratio 3.5: 4/14 and 11/14
// - bus and system outputs change at the rising edge
// - programmable machine outputs change on the selected tick
// - SDRAM and chip-select machine outputs change at rising edge only
// - module clock is bus clock times its module factor
// - core clock is bus clock times the core factor
module clock_mode_and_tick_generator (
  input wire logic clock,
  input wire logic nrst,
  input wire logic hostEnableStrap,
  input wire logic [31:0] cfgWord,
  input wire logic [2:0] modeCodePinBits,
  input wire logic busInputClock,
  input wire logic [7:0] busOutNext,
  input wire logic [7:0] pgmOutNext,
  input wire logic [7:0] sdramOutNext,
  input wire logic [7:0] gcsmOutNext,
  output logic [7:0] busOut,
  output logic [7:0] pgmOut,
  output logic [7:0] sdramOut,
  output logic [7:0] gcsmOut,
  output logic [3:0] ticks,
  output logic [6:0] modeCode,
  output logic busRangeSelect,
  output logic agentMode,
  output logic modeValid,
  output logic busClockIsInput,
  output logic [3:0] modMultX2,
  output logic [4:0] coreMultX2,
  output logic [3:0] pciDivFactor,
  input wire logic [clk_mode_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [clk_mode_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import clk_mode_pkg::*;

  tick_if tk ();

  // ====================
  // pin synchronisers
  logic busClkSync1, busClkSync2, busClkSync3;
  logic [8:0] strapSync1, strapSync2;

  always_ff @(posedge clock) begin
    busClkSync1 <= busInputClock;
    busClkSync2 <= busClkSync1;
    busClkSync3 <= busClkSync2;
    strapSync1 <= {hostEnableStrap, cfgWord[CFG_RANGE_BIT], cfgWord[CFG_UPPER_HI:CFG_UPPER_LO],
                   modeCodePinBits};
    strapSync2 <= strapSync1;
  end

  assign tk.busRise = busClkSync2 && !busClkSync3;
  assign tk.busFall = !busClkSync2 && busClkSync3;
  assign tk.ratioX2 = modMultX2;
  assign ticks = tk.tick;

  tick_phase_gen ticker (
    .clock(clock),
    .nrst(nrst),
    .tk(tk.gen)
  );

  // ====================
  // mode table
  function automatic factors_t fac(input int c2, input int u2, input int d);
    fac.valid = 1'b1;
    fac.modX2 = 4'(c2);
    fac.coreX2 = 5'(u2);
    fac.pciDiv = 4'(d);
  endfunction : fac

  function automatic factors_t mode_lookup(input logic [7:0] key);
    factors_t f;
    f = '0;
    case (key)
      8'h00: f = fac(4, 5, 2);
      8'h01: f = fac(4, 6, 2);
      8'h02: f = fac(5, 6, 3);
      8'h03: f = fac(5, 7, 3);
      8'h04: f = fac(5, 8, 3);
      8'h05: f = fac(6, 6, 3);
      8'h07: f = fac(6, 8, 3);
      8'h08: f = fac(6, 10, 3);
      8'h09: f = fac(6, 12, 3);
      8'h0A: f = fac(6, 14, 3);
      8'h0B: f = fac(6, 16, 3);
      8'h10: f = fac(8, 10, 4);
      8'h11: f = fac(8, 12, 4);
      8'h12: f = fac(8, 14, 4);
      8'h13: f = fac(8, 16, 4);
      8'h14: f = fac(8, 10, 6);
      8'h15: f = fac(8, 11, 6);
      8'h16: f = fac(8, 12, 6);
      8'h18: f = fac(10, 10, 5);
      8'h19: f = fac(10, 12, 5);
      8'h1A: f = fac(10, 14, 5);
      8'h1B: f = fac(10, 16, 5);
      8'h21: f = fac(12, 12, 6);
      8'h22: f = fac(12, 14, 6);
      8'h23: f = fac(12, 16, 6);
      8'h28: f = fac(4, 5, 2);
      8'h29: f = fac(4, 6, 2);
      8'h2B: f = fac(4, 8, 2);
      8'h2C: f = fac(4, 9, 2);
      8'h2D: f = fac(6, 7, 5);
      8'h2E: f = fac(6, 8, 5);
      8'h2F: f = fac(6, 9, 5);
      8'h30: f = fac(5, 5, 3);
      8'h31: f = fac(5, 6, 3);
      8'h32: f = fac(5, 7, 3);
      8'h33: f = fac(5, 8, 3);
      8'h34: f = fac(5, 9, 3);
      8'h35: f = fac(5, 10, 3);
      8'h36: f = fac(5, 12, 3);
      8'h39: f = fac(6, 6, 3);
      8'h3B: f = fac(6, 8, 3);
      8'h3C: f = fac(6, 9, 3);
      8'h41: f = fac(6, 6, 4);
      8'h42: f = fac(6, 7, 4);
      8'h43: f = fac(6, 8, 4);
      8'h44: f = fac(6, 9, 4);
      8'h45: f = fac(6, 12, 4);
      8'h46: f = fac(6, 13, 4);
      8'h48: f = fac(7, 5, 4);
      8'h49: f = fac(7, 6, 4);
      8'h4A: f = fac(7, 7, 4);
      8'h4B: f = fac(7, 8, 4);
      8'h4C: f = fac(7, 9, 4);
      8'h4D: f = fac(7, 10, 6);
      8'h4E: f = fac(7, 11, 6);
      8'h4F: f = fac(7, 12, 6);
      8'h50: f = fac(4, 4, 3);
      8'h51: f = fac(4, 5, 3);
      8'h52: f = fac(4, 6, 3);
      8'h53: f = fac(4, 7, 3);
      8'h54: f = fac(4, 8, 3);
      8'h55: f = fac(4, 5, 4);
      8'h56: f = fac(4, 6, 4);
      8'h57: f = fac(4, 7, 4);
      8'h59: f = fac(5, 5, 4);
      8'h5A: f = fac(5, 6, 4);
      8'h5B: f = fac(5, 7, 4);
      8'h5C: f = fac(5, 8, 4);
      8'h5D: f = fac(5, 9, 4);
      8'h68: f = fac(5, 6, 5);
      8'h69: f = fac(5, 7, 5);
      8'h6A: f = fac(5, 8, 5);
      8'h6B: f = fac(5, 9, 5);
      8'h6C: f = fac(5, 10, 5);
      8'h6D: f = fac(4, 6, 5);
      8'h6E: f = fac(4, 8, 5);
      8'h70: f = fac(6, 7, 6);
      8'h71: f = fac(6, 8, 6);
      8'h72: f = fac(6, 9, 6);
      8'h73: f = fac(6, 10, 6);
      8'h74: f = fac(6, 11, 6);
      8'h80: f = fac(4, 5, 4);
      8'h81: f = fac(4, 6, 4);
      8'h82: f = fac(5, 6, 6);
      8'h83: f = fac(5, 7, 6);
      8'h84: f = fac(5, 8, 6);
      8'h85: f = fac(6, 6, 6);
      8'h86: f = fac(6, 7, 6);
      8'h87: f = fac(6, 8, 6);
      8'h88: f = fac(6, 10, 6);
      8'h89: f = fac(6, 12, 6);
      8'h8A: f = fac(6, 14, 6);
      8'h8B: f = fac(6, 16, 6);
      8'h90: f = fac(8, 10, 8);
      8'h91: f = fac(8, 12, 8);
      8'h92: f = fac(8, 14, 8);
      8'h93: f = fac(8, 16, 8);
      8'h94: f = fac(8, 10, 6);
      8'h95: f = fac(8, 11, 6);
      8'h96: f = fac(8, 12, 6);
      8'h98: f = fac(10, 10, 5);
      8'h99: f = fac(10, 12, 5);
      8'h9A: f = fac(10, 14, 5);
      8'h9B: f = fac(10, 16, 5);
      8'hA1: f = fac(12, 12, 6);
      8'hA2: f = fac(12, 14, 6);
      8'hA3: f = fac(12, 16, 6);
      8'hA8: f = fac(4, 5, 4);
      8'hA9: f = fac(4, 6, 4);
      8'hAA: f = fac(4, 7, 4);
      8'hAB: f = fac(4, 8, 4);
      8'hAC: f = fac(4, 9, 4);
      8'hAD: f = fac(6, 7, 5);
      8'hAE: f = fac(6, 8, 5);
      8'hAF: f = fac(6, 9, 5);
      8'hB0: f = fac(5, 5, 6);
      8'hB1: f = fac(5, 6, 6);
      8'hB2: f = fac(5, 7, 6);
      8'hB3: f = fac(5, 8, 6);
      8'hB4: f = fac(5, 9, 6);
      8'hB5: f = fac(5, 10, 6);
      8'hB6: f = fac(5, 12, 6);
      8'hB9: f = fac(6, 6, 6);
      8'hBA: f = fac(6, 7, 6);
      8'hBB: f = fac(6, 8, 6);
      8'hBC: f = fac(6, 9, 6);
      8'hC1: f = fac(6, 6, 8);
      8'hC2: f = fac(6, 7, 8);
      8'hC3: f = fac(6, 8, 8);
      8'hC4: f = fac(6, 9, 8);
      8'hC5: f = fac(6, 12, 8);
      8'hC6: f = fac(6, 13, 8);
      8'hCA: f = fac(7, 7, 8);
      8'hCB: f = fac(7, 8, 8);
      8'hCC: f = fac(7, 9, 8);
      8'hCD: f = fac(7, 10, 6);
      8'hCE: f = fac(7, 11, 6);
      8'hCF: f = fac(7, 12, 6);
      8'hD0: f = fac(4, 4, 6);
      8'hD1: f = fac(4, 5, 6);
      8'hD2: f = fac(4, 6, 6);
      8'hD3: f = fac(4, 7, 6);
      8'hD4: f = fac(4, 8, 6);
      8'hD5: f = fac(4, 5, 8);
      8'hD6: f = fac(4, 6, 8);
      default: f = '0;
    endcase
    return f;
  endfunction : mode_lookup

  // ====================
  // capture at power-on reset
  cap_state_t capState, next_capState;
  factors_t fac_q, next_fac;
  logic [6:0] next_modeCode;
  logic next_range, next_agent;

  always_comb begin
    next_capState = capState;
    next_modeCode = modeCode;
    next_range = busRangeSelect;
    next_agent = agentMode;
    next_fac = fac_q;
    unique case (capState)
      CAP_WAIT: begin
        next_capState = CAP_HELD;
        next_modeCode = strapSync2[6:0];
        next_range = strapSync2[7];
        next_agent = strapSync2[8];
        next_fac = strapSync2[8] ? '0 : mode_lookup(strapSync2[7:0]);
      end
      CAP_HELD: begin
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      capState <= CAP_WAIT;
      modeCode <= 7'h00;
      busRangeSelect <= 1'b0;
      agentMode <= 1'b0;
      fac_q <= '0;
    end else begin
      capState <= next_capState;
      modeCode <= next_modeCode;
      busRangeSelect <= next_range;
      agentMode <= next_agent;
      fac_q <= next_fac;
    end
  end

  assign modeValid = fac_q.valid;
  assign busClockIsInput = (capState == CAP_HELD) && !agentMode;
  assign modMultX2 = fac_q.modX2;
  assign coreMultX2 = fac_q.coreX2;
  assign pciDivFactor = fac_q.pciDiv;

  // ====================
  // memory controller and bus outputs
  logic [1:0] pgmTickSel;
  logic [7:0] next_busOut, next_pgmOut, next_sdramOut, next_gcsmOut;

  always_comb begin
    next_busOut = tk.tick[0] ? busOutNext : busOut;
    next_sdramOut = tk.tick[0] ? sdramOutNext : sdramOut;
    next_gcsmOut = tk.tick[0] ? gcsmOutNext : gcsmOut;
    next_pgmOut = tk.tick[pgmTickSel] ? pgmOutNext : pgmOut;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      busOut <= 8'h00;
      pgmOut <= 8'h00;
      sdramOut <= 8'h00;
      gcsmOut <= 8'h00;
    end else begin
      busOut <= next_busOut;
      pgmOut <= next_pgmOut;
      sdramOut <= next_sdramOut;
      gcsmOut <= next_gcsmOut;
    end
  end

  // ====================
  // register slave
  logic awHeld, next_awHeld, wHeld, next_wHeld, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] awAddrQ, next_awAddrQ;
  logic [31:0] wDataQ, next_wDataQ, next_rdata, rword;
  logic wStrb0Q, next_wStrb0Q;
  logic [1:0] next_bresp, next_rresp, next_pgmTickSel;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFS_MODE_STATUS) || (a == OFS_FACTORS) || (a == OFS_TICK_CTRL)
                || (a == OFS_TICK_STATUS);
  endfunction : is_mapped

  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  assign arready = !rvalid;

  always_comb begin
    rword = 32'h0000_0000;
    unique case (araddr)
      OFS_MODE_STATUS: begin
        rword[6:0] = modeCode;
        rword[ST_RANGE] = busRangeSelect;
        rword[ST_AGENT] = agentMode;
        rword[ST_VALID] = fac_q.valid;
        rword[ST_CAPT] = (capState == CAP_HELD);
      end
      OFS_FACTORS: begin
        rword[3:0] = fac_q.modX2;
        rword[FAC_CORE_LO +: 5] = fac_q.coreX2;
        rword[FAC_PCI_LO +: 4] = fac_q.pciDiv;
      end
      OFS_TICK_CTRL: rword[1:0] = pgmTickSel;
      OFS_TICK_STATUS: begin
        rword[PERIOD_W-1:0] = tk.period;
        rword[TS_TICK_LO +: 4] = tk.tick;
      end
      default: rword = 32'h0000_0000;
    endcase
    next_awHeld = awHeld | (awvalid && awready);
    next_awAddrQ = (awvalid && awready) ? awaddr : awAddrQ;
    next_wHeld = wHeld | (wvalid && wready);
    next_wDataQ = (wvalid && wready) ? wdata : wDataQ;
    next_wStrb0Q = (wvalid && wready) ? wstrb[0] : wStrb0Q;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_pgmTickSel = pgmTickSel;
    if (awHeld && wHeld) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(awAddrQ) ? RESP_OKAY : RESP_SLVERR;
      if (awAddrQ == OFS_TICK_CTRL && wStrb0Q) begin
        next_pgmTickSel = wDataQ[1:0];
      end
    end
    next_rvalid = rvalid && !rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata = rword;
      next_rresp = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= 32'h0000_0000;
      wStrb0Q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      pgmTickSel <= PGM_TICK_RESET;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddrQ <= next_awAddrQ;
      wDataQ <= next_wDataQ;
      wStrb0Q <= next_wStrb0Q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      pgmTickSel <= next_pgmTickSel;
    end
  end

  // ====================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_mode_held: assert property (capState == CAP_HELD |=>
    $stable(modeCode) && $stable(fac_q))
    else $error("mode changed outside power-on reset");
  a_range_bit: assert property (nrst && capState == CAP_WAIT |=>
    busRangeSelect == $past(strapSync2[7]))
    else $error("range bit not captured");
  a_code_bits: assert property (nrst && capState == CAP_WAIT |=>
    modeCode == $past(strapSync2[6:0]))
    else $error("mode code not captured");
  a_host_clock: assert property (capState == CAP_HELD |-> busClockIsInput == !agentMode)
    else $error("host mode bus clock wrong");
  a_bus_rise: assert property (tk.tick[0] |=> busOut == $past(busOutNext))
    else $error("bus output missed rising edge");
  a_sdram_hold: assert property (!tk.tick[0] |=> $stable(sdramOut) && $stable(gcsmOut))
    else $error("machine output changed off rising edge");
  a_pgm_tick: assert property (tk.tick[pgmTickSel] |=> pgmOut == $past(pgmOutNext))
    else $error("programmable output missed its tick");
  c_capture: cover property (capState == CAP_WAIT ##1 capState == CAP_HELD && modeValid);
  c_pgm_second: cover property (pgmTickSel == 2'h1 && tk.tick[1]);
  c_write_resp: cover property (bvalid && bready && bresp == RESP_OKAY);
  c_half_ratio: cover property (modMultX2 == RATIO_2P5_X2 && tk.tick[3]);
endmodule : clock_mode_and_tick_generator
`default_nettype wire

// ==== tb/strap_source.sv ====
/*
  board straps, configuration word and free running bus input clock.
  assumes the bench calls present just after a rising edge of clock.
*/
`default_nettype none
module strap_source #(parameter int HALF = 28) (
  input wire logic clock,
  output logic hostEnableStrap,
  output logic [31:0] cfgWord,
  output logic [2:0] modeCodePinBits,
  output logic busInputClock
);
  timeunit 1ns;
  timeprecision 100ps;
  int n = 0;
  initial begin
    hostEnableStrap = 1'b0;
    cfgWord = 32'h0000_0000;
    modeCodePinBits = 3'h0;
    busInputClock = 1'b0;
  end
  // ====================
  // bus input clock, period of 2 * HALF clocks
  always @(posedge clock) begin
    n <= (n == HALF - 1) ? 0 : n + 1;
    if (n == HALF - 1)
      busInputClock <= ~busInputClock;
  end
  task automatic present(input logic ag, input logic rg, input logic [6:0] c);
    hostEnableStrap <= ag;
    cfgWord <= {c[6:3], rg, 27'h000_0000};
    modeCodePinBits <= c[2:0];
  endtask : present
endmodule : strap_source
`default_nettype wire

// ==== tb/clock_mode_and_tick_generator_bench.sv ====
/*
  self-checking bench of the clock mode and tick generator.
  assumes the strap source model with a bus input clock period of 56 clocks.
*/
`default_nettype none
module clock_mode_and_tick_generator_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import clk_mode_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic hostEnableStrap, busRangeSelect, agentMode, modeValid, busClockIsInput, busInputClock;
  logic [31:0] cfgWord, rdata;
  logic [2:0] modeCodePinBits;
  logic [7:0] cnt = 8'h00, busOut, pgmOut, sdramOut, gcsmOut, lBus, lPgm, lSd, lGp;
  logic [3:0] ticks, modMultX2, pciDivFactor, prevT;
  logic [6:0] modeCode;
  logic [4:0] coreMultX2;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, lRdy;
  logic [1:0] bresp, rresp, sel = 2'h0;
  int err_total = 0, tests_run = 0;
  initial forever #5 clock = ~clock;
  always @(posedge clock) cnt <= cnt + 8'h01;
  strap_source u_strap_source (.clock, .hostEnableStrap, .cfgWord, .modeCodePinBits,
    .busInputClock);
  clock_mode_and_tick_generator u_clock_mode_and_tick_generator (.clock, .nrst,
    .hostEnableStrap, .cfgWord, .modeCodePinBits, .busInputClock, .busOutNext(cnt),
    .pgmOutNext(cnt), .sdramOutNext(cnt), .gcsmOutNext(cnt), .busOut, .pgmOut, .sdramOut,
    .gcsmOut, .ticks, .modeCode, .busRangeSelect, .agentMode, .modeValid, .busClockIsInput,
    .modMultX2, .coreMultX2, .pciDivFactor, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready);
  // ====================
  // output timing monitor
  always @(negedge clock) begin
    if (nrst && busOut !== lBus) chk("bus out", prevT[0], 1'b1);
    if (nrst && pgmOut !== lPgm && !bready && !lRdy) chk("pgm out", prevT[sel], 1'b1);
    if (nrst && sdramOut !== lSd) chk("sdram out", prevT[0], 1'b1);
    if (nrst && gcsmOut !== lGp) chk("gcsm out", prevT[0], 1'b1);
    prevT <= ticks;
    lBus <= busOut;
    lPgm <= pgmOut;
    lSd <= sdramOut;
    lGp <= gcsmOut;
    lRdy <= bready;
  end
  // ====================
  // shared tasks
  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results;
    if (err_total == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  task automatic failWait;
    err_total++;
    results();
  endtask : failWait
  task automatic doReset(input logic ag, input logic rg, input logic [6:0] c);
    @(posedge clock);
    u_strap_source.present(ag, rg, c);
    nrst <= 1'b0;
    sel = 2'h0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask : doReset
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aHit, wHit, bHit;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clock);
      aHit = awvalid & awready;
      wHit = wvalid & wready;
      bHit = bvalid;
      r = bresp;
      @(posedge clock);
      if (aHit) awvalid <= 1'b0;
      if (wHit) wvalid <= 1'b0;
      if (bHit) break;
    end
    bready <= 1'b0;
    if (n == 50) failWait();
  endtask : axiWrite
  task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic aHit, rHit;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge clock);
      aHit = arvalid & arready;
      rHit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (aHit) arvalid <= 1'b0;
      if (rHit) break;
    end
    rready <= 1'b0;
    if (n == 50) failWait();
  endtask : axiRead
  function automatic logic near(input int d, input int num, input int den);
    return d * den >= 56 * num - den && d * den <= 56 * num + 2 * den;
  endfunction : near
  task automatic ticksAt(input int n2, input int n4, input int den);
    int t, k, base;
    int at [4];
    k = 0;
    base = -1;
    at = '{-1, -1, -1, -1};
    for (t = 0; t < 800 && at[3] < 0; t++) begin
      @(negedge clock);
      if (ticks[0] === 1'b1) k++;
      if (ticks[0] === 1'b1 && k == 3) base = t;
      for (int i = 1; i < 4; i++)
        if (base >= 0 && ticks[i] === 1'b1 && at[i] < 0) at[i] = t - base;
    end
    if (at[3] < 0) failWait();
    chk("tick second", near(at[1], n2, den), 1'b1);
    chk("tick third", near(at[2], 1, 2), 1'b1);
    chk("tick fourth", near(at[3], n4, den), 1'b1);
  endtask : ticksAt
  // ====================
  // scenarios
  task automatic modeCase(input logic ag, input logic rg, input logic [6:0] c,
      input logic [3:0] mx, input logic [4:0] core, input logic [3:0] pci, input int n2,
      input int n4, input int den);
    logic [31:0] v;
    logic [1:0] r;
    doReset(ag, rg, c);
    chk("code", modeCode, c);
    chk("range", busRangeSelect, rg);
    chk("agent", agentMode, ag);
    chk("host clock", busClockIsInput, !ag);
    chk("valid", modeValid, mx != 4'h0);
    chk("module x2", modMultX2, mx);
    chk("core x2", coreMultX2, core);
    chk("pci div", pciDivFactor, pci);
    axiRead(OFS_FACTORS, v, r);
    chk("factors", v, {16'h0000, pci, 3'h0, core, mx});
    if (den != 0) ticksAt(n2, n4, den);
  endtask : modeCase
  task automatic regsCase;
    logic [31:0] v;
    logic [1:0] r;
    doReset(1'b0, 1'b0, 7'h00);
    @(posedge clock);
    u_strap_source.present(1'b0, 1'b1, 7'h06);
    ticksAt(1, 3, 4);
    chk("code held", {busRangeSelect, modeCode}, 8'h00);
    axiRead(OFS_MODE_STATUS, v, r);
    chk("status", v, 32'h0000_0600);
    axiWrite(OFS_TICK_CTRL, 32'h0000_0003, r);
    sel = 2'h3;
    axiRead(OFS_TICK_CTRL, v, r);
    chk("tick sel", v, 32'h0000_0003);
    ticksAt(1, 3, 4);
    axiWrite(OFS_FACTORS, 32'hFFFF_FFFF, r);
    axiRead(OFS_FACTORS, v, r);
    chk("factors ro", {r, v}, {RESP_OKAY, 32'h0000_2054});
    axiRead(4'h2, v, r);
    chk("unaligned rd", {r, v}, {RESP_SLVERR, 32'h0000_0000});
    axiWrite(4'h6, 32'h0000_0001, r);
    chk("unaligned wr", r, RESP_SLVERR);
  endtask : regsCase
  initial begin
    modeCase(1'b0, 1'b0, 7'h00, 4'h4, 5'h05, 4'h2, 1, 3, 4);
    modeCase(1'b0, 1'b0, 7'h68, 4'h5, 5'h06, 4'h5, 3, 8, 10);
    modeCase(1'b0, 1'b0, 7'h4D, 4'h7, 5'h0A, 4'h6, 4, 11, 14);
    modeCase(1'b0, 1'b1, 7'h06, 4'h6, 5'h07, 4'h6, 1, 3, 4);
    modeCase(1'b0, 1'b0, 7'h20, 4'h0, 5'h00, 4'h0, 0, 0, 0);
    modeCase(1'b1, 1'b0, 7'h00, 4'h0, 5'h00, 4'h0, 0, 0, 0);
    regsCase();
    results();
  end
endmodule : clock_mode_and_tick_generator_bench
`default_nettype wire
